// ==== design/adcts_pkg.sv ====
// package: register map, fields, encodings and timing of the converter control
package adcts_pkg;
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned RES_W  = 10;

   // register offsets
   localparam logic [2:0] OFF_CTRL0  = 3'h0;
   localparam logic [2:0] OFF_CTRL1  = 3'h1;
   localparam logic [2:0] OFF_FREF   = 3'h2;
   localparam logic [2:0] OFF_RES_HI = 3'h3;
   localparam logic [2:0] OFF_RES_LO = 3'h4;
   localparam logic [2:0] OFF_STATUS = 3'h5;
   localparam logic [2:0] OFF_MASK   = 3'h6;

   // converter_control_0 fields
   localparam int unsigned C0_ON_BIT   = 0;
   localparam int unsigned C0_GO_BIT   = 1;
   localparam int unsigned C0_CHS_LSB  = 2;
   localparam int unsigned C0_TRDY_BIT = 7;
   // converter_control_1 fields
   localparam int unsigned C1_PREF_LSB = 0;
   localparam int unsigned C1_CS_LSB   = 4;
   localparam int unsigned C1_FMT_BIT  = 7;
   // fixed_reference_control fields
   localparam int unsigned FR_REN_BIT  = 7;
   localparam int unsigned FR_RDY_BIT  = 6;
   localparam int unsigned FR_TEMP_SENSE_ENABLE_BIT = 5;
   localparam int unsigned FR_TRNG_BIT = 4;
   localparam int unsigned FR_PG_LSB   = 2;
   localparam int unsigned FR_CG_LSB   = 0;
   // status and mask fields
   localparam int unsigned ST_DONE_BIT = 0;
   localparam int unsigned ST_REF_BIT  = 1;
   localparam int unsigned ST_W        = 2;

   // reset values
   localparam logic [7:0] RST_CTRL0 = 8'h00;
   localparam logic [7:0] RST_CTRL1 = 8'h00;
   localparam logic [7:0] RST_FREF  = 8'h00;
   localparam logic [1:0] RST_MASK  = 2'h0;

   // conversion clock select encodings
   localparam logic [2:0] CS_DIV2  = 3'h0;
   localparam logic [2:0] CS_DIV4  = 3'h4;
   localparam logic [2:0] CS_DIV8  = 3'h1;
   localparam logic [2:0] CS_DIV16 = 3'h5;
   localparam logic [2:0] CS_DIV32 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h6;
   localparam logic [1:0] CS_RC_LO = 2'h3;

   // positive reference encodings
   localparam logic [1:0] PREF_VDD   = 2'h0;
   localparam logic [1:0] PREF_PIN   = 2'h1;
   localparam logic [1:0] PREF_FR2X  = 2'h2;
   localparam logic [1:0] PREF_FR4X  = 2'h3;

   // reference gain encodings
   localparam logic [1:0] GAIN_OFF = 2'h0;
   localparam logic [1:0] GAIN_1X  = 2'h1;
   localparam logic [1:0] GAIN_2X  = 2'h2;
   localparam logic [1:0] GAIN_4X  = 2'h3;

   // internal channel codes
   localparam logic [4:0] CH_TEMP = 5'h1d;
   localparam logic [4:0] CH_DAC  = 5'h1e;
   localparam logic [4:0] CH_FREF = 5'h1f;

   // conversion timing in half bit periods
   localparam logic [4:0] SAMPLE_HALVES = 5'h03;
   localparam logic [4:0] LAST_HALF     = 5'h16;
   localparam logic [3:0] TOP_BIT       = 4'h9;

   // timing
   localparam int unsigned CLK_MHZ          = 100;
   localparam int unsigned TEMP_SETTLE_US   = 200;
   localparam int unsigned TEMP_SETTLE_CYC  = TEMP_SETTLE_US * CLK_MHZ;
   localparam int unsigned REF_SETTLE_CYC   = 64;

   // controls toward the analog core
   typedef struct packed {
      logic       conv_on;
      logic       sample;
      logic [4:0] channel;
      logic       chan_valid;
      logic [1:0] pos_ref;
      logic [9:0] trial_code;
      logic       ref_en;
      logic       temp_en;
      logic       temp_high;
      logic [1:0] periph_gain;
      logic [1:0] conv_gain;
   } adcts_ana_t;

   // register bus request
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } adcts_req_t;
endpackage : adcts_pkg

// ==== design/adcts_top.sv ====
// converter control with temperature sense, reference control and interrupt
// Function
// - standard-voltage variant reports reference ready as one at all times.
// - temperature sense enable bit switches the temperature indicator on or off.
// - range select bit set picks high range, cleared picks low range.
// - successive approximation yields a 10-bit result in high/low result pair.
// - conversion completion raises an interrupt that can also wake from sleep.
// - seven or eleven inputs: four or eight pins plus temperature, DAC, reference.
// - channel select field picks the input routed to sample-and-hold.
// - positive reference: pin, supply, 2.048V, or 4.096V except low-voltage.
// - seven conversion clocks: system clock over 2 to 64, or RC oscillator.
// - one bit per conversion clock period, full conversion 11.5 periods.
// - divided sources follow system clock; only RC source is independent.
// - clock select codes 000,100,001,101,010,110 for dividers, x11 for RC.
// - completion clears busy, sets done flag, updates both result registers.
// - gain fields encode off, 1x, 2x, 4x for peripherals and converter.
// - low-voltage reference ready reads one when ready, zero when not ready or disabled.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module adcts_top #(
   parameter int unsigned PIN_COUNT       = 4,
   parameter bit          LOW_VOLTAGE     = 1'b0,
   parameter int unsigned REF_SETTLE      = adcts_pkg::REF_SETTLE_CYC,
   parameter int unsigned TEMP_SETTLE     = adcts_pkg::TEMP_SETTLE_CYC
) (
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   // register port
   input  wire logic [2:0]            addr,
   input  wire logic [7:0]            wr_data,
   input  wire logic                  wr_en,
   input  wire logic                  rd_en,
   output logic      [7:0]            rd_data,
   // analog core
   input  wire logic                  cmp_in,
   input  wire logic                  rc_osc,
   input  wire logic                  ref_stable,
   output adcts_pkg::adcts_ana_t      ana,
   // power and interrupt
   input  wire logic                  sleep,
   output logic                       irq,
   output logic                       wake
);
   initial begin
      if (PIN_COUNT != 4 && PIN_COUNT != 8)
         $error("PIN_COUNT must be 4 or 8");
      if (REF_SETTLE < 1 || REF_SETTLE > 65535)
         $error("REF_SETTLE out of range");
      if (TEMP_SETTLE < 1 || TEMP_SETTLE > 65535)
         $error("TEMP_SETTLE out of range");
   end

   localparam logic [15:0] REF_LIM  = 16'(REF_SETTLE - 1);
   localparam logic [15:0] TEMP_LIM = 16'(TEMP_SETTLE - 1);
   localparam logic [4:0]  PIN_LIM  = 5'(PIN_COUNT);

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_CONV   = 3'b100
   } adcts_fsm_t;

   typedef struct packed {
      adcts_fsm_t             fsm;
      logic                   on;
      logic [4:0]             channel_select;
      logic [1:0]             pref;
      logic [2:0]             cs;
      logic                   fmt;
      logic                   ref_en;
      logic                   temp_sense_enable;
      logic                   temp_range_select;
      logic [1:0]             pgain;
      logic [1:0]             cgain;
      logic [9:0]             res;
      logic [9:0]             sar;
      logic                   lastbit;
      logic [3:0]             bitidx;
      logic [4:0]             hcnt;
      logic [5:0]             div;
      logic [1:0]             status;
      logic [1:0]             mask;
      logic [7:0]             rd_data;
      logic                   irq;
      logic                   wake;
      logic                   rc_s1;
      logic                   rc_s2;
      logic                   rc_s3;
      logic                   cmp_s1;
      logic                   cmp_s2;
      logic                   rdy_s1;
      logic                   rdy_s2;
      logic [15:0]            ref_cnt;
      logic                   ref_rdy;
      logic [15:0]            temp_cnt;
      logic                   temp_rdy;
      adcts_pkg::adcts_ana_t  ana;
   } adcts_state_t;

   adcts_state_t st_r;
   adcts_state_t st_nxt;

   // half of one bit period in system clocks for each divider code
   function automatic logic [5:0] adcts_half(input logic [2:0] sel);
      logic [5:0] h;
      h = 6'h01;
      unique case (sel)
         adcts_pkg::CS_DIV2:  h = 6'h01;
         adcts_pkg::CS_DIV4:  h = 6'h02;
         adcts_pkg::CS_DIV8:  h = 6'h04;
         adcts_pkg::CS_DIV16: h = 6'h08;
         adcts_pkg::CS_DIV32: h = 6'h10;
         adcts_pkg::CS_DIV64: h = 6'h20;
         default:             h = 6'h01;
      endcase
      return h;
   endfunction : adcts_half

   logic       req_wr;
   logic       use_rc;
   logic       half_tick;
   logic       busy;
   logic       go_set;
   logic       go_clr;
   logic       finish;
   logic       abort;
   logic       decide;
   logic       bitval;
   logic [9:0] trial;
   logic [9:0] fill;
   logic [9:0] final_res;
   logic [1:0] st_set;
   logic       ref_ready_view;
   logic [7:0] c0_view;
   logic [7:0] c1_view;
   logic [7:0] fr_view;
   logic [7:0] hi_view;
   logic [7:0] lo_view;

   always_comb begin
      st_nxt = st_r;
      req_wr = wr_en;

      // two-stage synchronisers for analog-side inputs
      st_nxt.rc_s1  = rc_osc;
      st_nxt.rc_s2  = st_r.rc_s1;
      st_nxt.rc_s3  = st_r.rc_s2;
      st_nxt.cmp_s1 = cmp_in;
      st_nxt.cmp_s2 = st_r.cmp_s1;
      st_nxt.rdy_s1 = ref_stable;
      st_nxt.rdy_s2 = st_r.rdy_s1;

      // conversion clock: divided system clock or RC edges
      use_rc = (st_r.cs[1:0] == adcts_pkg::CS_RC_LO);
      busy   = (st_r.fsm != ST_IDLE);
      if (use_rc) begin
         // rc timing is independent of the system clock
         half_tick  = st_r.rc_s2 ^ st_r.rc_s3;
         st_nxt.div = 6'h00;
      end else begin
         // counts system clocks, so tracks any system clock change
         half_tick = busy && (st_r.div == adcts_half(st_r.cs) - 6'h01);
         if (!busy || half_tick)
            st_nxt.div = 6'h00;
         else
            st_nxt.div = st_r.div + 6'h01;
      end

      // register writes
      go_set = 1'b0;
      go_clr = 1'b0;
      if (req_wr) begin
         unique case (addr)
            adcts_pkg::OFF_CTRL0: begin
               st_nxt.on  = wr_data[adcts_pkg::C0_ON_BIT];
               st_nxt.channel_select = wr_data[adcts_pkg::C0_CHS_LSB +: 5];
               go_set = wr_data[adcts_pkg::C0_GO_BIT] && st_r.on;
               go_clr = !wr_data[adcts_pkg::C0_GO_BIT];
            end
            adcts_pkg::OFF_CTRL1: begin
               st_nxt.fmt = wr_data[adcts_pkg::C1_FMT_BIT];
               st_nxt.cs  = wr_data[adcts_pkg::C1_CS_LSB +: 3];
               // 4.096V choice refused on low-voltage parts
               if (!(LOW_VOLTAGE && wr_data[adcts_pkg::C1_PREF_LSB +: 2]
                     == adcts_pkg::PREF_FR4X))
                  st_nxt.pref = wr_data[adcts_pkg::C1_PREF_LSB +: 2];
            end
            adcts_pkg::OFF_FREF: begin
               st_nxt.ref_en = wr_data[adcts_pkg::FR_REN_BIT];
               st_nxt.temp_sense_enable   = wr_data[adcts_pkg::FR_TEMP_SENSE_ENABLE_BIT];
               st_nxt.temp_range_select  = wr_data[adcts_pkg::FR_TRNG_BIT];
               st_nxt.pgain  = wr_data[adcts_pkg::FR_PG_LSB +: 2];
               st_nxt.cgain  = wr_data[adcts_pkg::FR_CG_LSB +: 2];
            end
            adcts_pkg::OFF_MASK:
               st_nxt.mask = wr_data[adcts_pkg::ST_W-1:0];
            default: ;
         endcase
      end

      // successive approximation sequencer
      trial  = st_r.sar | (10'h001 << st_r.bitidx);
      // decide as each bit period ends; at /2 the sync delay is too long
      decide = half_tick && (st_r.fsm == ST_CONV) && !st_r.hcnt[0];
      bitval = st_r.cmp_s2;
      finish = decide && (st_r.hcnt == adcts_pkg::LAST_HALF);
      // sleep on a system-clock source stops the conversion, result untouched
      abort  = busy && sleep && !use_rc;
      fill   = st_r.lastbit ? ((10'h001 << (st_r.bitidx + 4'h1)) - 10'h001)
                            : 10'h000;
      final_res = st_r.sar | fill;
      st_set = '0;

      unique case (st_r.fsm)
         ST_IDLE: begin
            if (go_set) begin
               st_nxt.fsm    = ST_SAMPLE;
               st_nxt.hcnt   = 5'h00;
               st_nxt.bitidx = adcts_pkg::TOP_BIT;
               st_nxt.sar    = 10'h000;
            end
         end
         ST_SAMPLE: begin
            // first 1.5 periods hold the sample, then ten bit periods
            if (half_tick) begin
               st_nxt.hcnt = st_r.hcnt + 5'h01;
               if (st_r.hcnt == adcts_pkg::SAMPLE_HALVES - 5'h01)
                  st_nxt.fsm = ST_CONV;
            end
         end
         ST_CONV: begin
            if (half_tick)
               st_nxt.hcnt = st_r.hcnt + 5'h01;
            if (decide) begin
               // one bit decided per conversion period
               st_nxt.sar     = bitval ? trial : st_r.sar;
               st_nxt.lastbit = bitval;
               st_nxt.bitidx  = st_r.bitidx - 4'h1;
            end
            if (finish) begin
               // completion updates result and raises done
               st_nxt.res = bitval ? trial : st_r.sar;
               st_nxt.fsm = ST_IDLE;
               st_set[adcts_pkg::ST_DONE_BIT] = 1'b1;
            end
         end
         default: st_nxt.fsm = ST_IDLE;
      endcase

      // software termination: partial bits copy the last decided bit
      if (busy && !finish && (go_clr || !st_nxt.on)) begin
         st_nxt.fsm = ST_IDLE;
         if (st_r.fsm == ST_CONV && st_r.bitidx != adcts_pkg::TOP_BIT)
            st_nxt.res = final_res;
      end else if (abort) begin
         st_nxt.fsm = ST_IDLE;
      end

      // fixed reference ready
      if (!st_r.ref_en) begin
         st_nxt.ref_cnt = 16'h0000;
         st_nxt.ref_rdy = 1'b0;
      end else if (st_r.ref_cnt != REF_LIM) begin
         st_nxt.ref_cnt = st_r.ref_cnt + 16'h0001;
      end else begin
         st_nxt.ref_rdy = st_r.rdy_s2;
      end
      ref_ready_view = LOW_VOLTAGE ? st_r.ref_rdy : 1'b1;
      if (st_nxt.ref_rdy && !st_r.ref_rdy)
         st_set[adcts_pkg::ST_REF_BIT] = 1'b1;

      // temperature settle indication, restarted by routing or a conversion
      if (st_r.channel_select != adcts_pkg::CH_TEMP || !st_r.temp_sense_enable
          || (busy && st_r.channel_select == adcts_pkg::CH_TEMP)) begin
         st_nxt.temp_cnt = 16'h0000;
         st_nxt.temp_rdy = 1'b0;
      end else if (st_r.temp_cnt != TEMP_LIM) begin
         st_nxt.temp_cnt = st_r.temp_cnt + 16'h0001;
      end else begin
         st_nxt.temp_rdy = 1'b1;
      end

      // read views
      c0_view = '0;
      c0_view[adcts_pkg::C0_ON_BIT]     = st_r.on;
      c0_view[adcts_pkg::C0_GO_BIT]     = busy;
      c0_view[adcts_pkg::C0_CHS_LSB +: 5] = st_r.channel_select;
      c0_view[adcts_pkg::C0_TRDY_BIT]   = st_r.temp_rdy;
      c1_view = '0;
      c1_view[adcts_pkg::C1_FMT_BIT]      = st_r.fmt;
      c1_view[adcts_pkg::C1_CS_LSB +: 3]  = st_r.cs;
      c1_view[adcts_pkg::C1_PREF_LSB +: 2] = st_r.pref;
      fr_view = '0;
      fr_view[adcts_pkg::FR_REN_BIT]    = st_r.ref_en;
      fr_view[adcts_pkg::FR_RDY_BIT]    = ref_ready_view;
      fr_view[adcts_pkg::FR_TEMP_SENSE_ENABLE_BIT]   = st_r.temp_sense_enable;
      fr_view[adcts_pkg::FR_TRNG_BIT]   = st_r.temp_range_select;
      fr_view[adcts_pkg::FR_PG_LSB +: 2] = st_r.pgain;
      fr_view[adcts_pkg::FR_CG_LSB +: 2] = st_r.cgain;
      // result pair in right or left justified form
      hi_view = st_r.fmt ? {6'h00, st_r.res[9:8]} : st_r.res[9:2];
      lo_view = st_r.fmt ? st_r.res[7:0] : {st_r.res[1:0], 6'h00};

      st_nxt.rd_data = 8'h00;
      if (rd_en) begin
         unique case (addr)
            adcts_pkg::OFF_CTRL0:  st_nxt.rd_data = c0_view;
            adcts_pkg::OFF_CTRL1:  st_nxt.rd_data = c1_view;
            adcts_pkg::OFF_FREF:   st_nxt.rd_data = fr_view;
            adcts_pkg::OFF_RES_HI: st_nxt.rd_data = hi_view;
            adcts_pkg::OFF_RES_LO: st_nxt.rd_data = lo_view;
            adcts_pkg::OFF_STATUS: st_nxt.rd_data = {6'h00, st_r.status};
            adcts_pkg::OFF_MASK:   st_nxt.rd_data = {6'h00, st_r.mask};
            default:               st_nxt.rd_data = 8'h00;
         endcase
      end

      // sticky status: read clears, a new event in the same cycle wins
      if (rd_en && addr == adcts_pkg::OFF_STATUS)
         st_nxt.status = st_set;
      else
         st_nxt.status = st_r.status | st_set;
      st_nxt.irq  = |(st_nxt.status & st_nxt.mask);
      st_nxt.wake = st_nxt.irq && sleep;

      // analog controls
      st_nxt.ana.conv_on     = st_nxt.on && !(sleep && !use_rc);
      st_nxt.ana.sample      = st_nxt.on && (st_nxt.fsm != ST_CONV);
      st_nxt.ana.channel     = st_nxt.channel_select;
      // pins below the pin count plus three internal inputs
      st_nxt.ana.chan_valid  = (st_nxt.channel_select < PIN_LIM)
                               || (st_nxt.channel_select == adcts_pkg::CH_TEMP)
                               || (st_nxt.channel_select == adcts_pkg::CH_DAC)
                               || (st_nxt.channel_select == adcts_pkg::CH_FREF);
      st_nxt.ana.pos_ref     = st_nxt.pref;
      st_nxt.ana.trial_code  = (st_nxt.fsm == ST_CONV)
                               ? (st_nxt.sar | (10'h001 << st_nxt.bitidx))
                               : 10'h000;
      st_nxt.ana.ref_en      = st_nxt.ref_en;
      st_nxt.ana.temp_en     = st_nxt.temp_sense_enable;
      st_nxt.ana.temp_high   = st_nxt.temp_range_select;
      st_nxt.ana.periph_gain = st_nxt.pgain;
      st_nxt.ana.conv_gain   = st_nxt.cgain;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r        <= '0;
         st_r.fsm    <= ST_IDLE;
         st_r.on     <= adcts_pkg::RST_CTRL0[adcts_pkg::C0_ON_BIT];
         st_r.cs     <= adcts_pkg::RST_CTRL1[adcts_pkg::C1_CS_LSB +: 3];
         st_r.pref   <= adcts_pkg::RST_CTRL1[adcts_pkg::C1_PREF_LSB +: 2];
         st_r.ref_en <= adcts_pkg::RST_FREF[adcts_pkg::FR_REN_BIT];
         st_r.mask   <= adcts_pkg::RST_MASK;
         st_r.bitidx <= adcts_pkg::TOP_BIT;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rd_data = st_r.rd_data;
   assign irq     = st_r.irq;
   assign wake    = st_r.wake;
   assign ana     = st_r.ana;
endmodule : adcts_top

// ==== test/adcts_monitor.sv ====
// checker: register effects on the analog controls, ready flag, irq and wake
`timescale 1ns/1ps
module adcts_monitor (
   // clock and reset
   input wire logic                  core_clk,
   input wire logic                  rst,
   // register port
   input wire logic [2:0]            addr,
   input wire logic [7:0]            wr_data,
   input wire logic                  wr_en,
   input wire logic                  rd_en,
   input wire logic [7:0]            rd_data,
   // analog core
   input wire logic                  cmp_in,
   input wire logic                  rc_osc,
   input wire logic                  ref_stable,
   input wire adcts_pkg::adcts_ana_t ana,
   // power and interrupt
   input wire logic                  sleep,
   input wire logic                  irq,
   input wire logic                  wake
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // a second write right behind would move the target, so it is excluded
   wire fw = wr_en && addr == adcts_pkg::OFF_FREF;
   wire c0w = wr_en && addr == adcts_pkg::OFF_CTRL0;
   wire c1w = wr_en && addr == adcts_pkg::OFF_CTRL1;
   temp_ctrl_a : assert property (fw ##1 !fw |=>
      ana.temp_en == $past(wr_data[5], 2) &&
      ana.temp_high == $past(wr_data[4], 2)) else $error("temp control off");
   gain_fields_a : assert property (fw ##1 !fw |=>
      {ana.periph_gain, ana.conv_gain} == $past(wr_data[3:0], 2))
      else $error("gain fields off");
   channel_route_a : assert property (c0w ##1 !c0w |=>
      ana.channel == $past(wr_data[6:2], 2)) else $error("channel off");
   pos_ref_a : assert property (c1w ##1 !c1w |=>
      ana.pos_ref == $past(wr_data[1:0], 2)) else $error("pos ref off");
   ready_read_a : assert property (rd_en &&
      addr == adcts_pkg::OFF_FREF |=> rd_data[6]) else $error("ready low");
   wake_raise_a : assert property (irq && sleep |->
      ##[0:1] wake) else $error("no wake");
   wake_quiet_a : assert property (!$past(sleep) |->
      !wake) else $error("wake while awake");
   mask_off_a : assert property (wr_en &&
      addr == adcts_pkg::OFF_MASK && wr_data[1:0] == 2'h0 |-> ##2 !irq)
      else $error("irq not masked");
endmodule : adcts_monitor
bind adcts_top adcts_monitor u_mon (.core_clk(core_clk), .rst(rst),
   .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
   .rd_data(rd_data), .cmp_in(cmp_in), .rc_osc(rc_osc),
   .ref_stable(ref_stable), .ana(ana), .sleep(sleep), .irq(irq),
   .wake(wake));

// ==== test/adcts_core_model.sv ====
// far-side model: input levels, comparator, rc oscillator, reference
`timescale 1ns/1ps
module adcts_core_model (
   // controls from the block
   input wire adcts_pkg::adcts_ana_t ana,
   // analog answers
   output logic                      cmp_in,
   output logic                      rc_osc,
   output logic                      ref_stable
);
   logic [9:0] vin;
   // each input level is built from its channel, so misrouting shows
   assign vin = {ana.channel, ana.channel};
   // answers at once: at /2 a slow comparator model would be too late
   assign cmp_in = ana.conv_on ? (vin >= ana.trial_code) : ana.trial_code[0];
   assign ref_stable = ana.ref_en;
   // free-running oscillator, 4 core cycles per edge
   initial begin
      rc_osc = 1'b0;
      forever #40 rc_osc = ~rc_osc;
   end
endmodule : adcts_core_model

// ==== test/tb.sv ====
// testbench: registers, conversions on every clock source, sleep and wake
`timescale 1ns/1ps
module tb;
   localparam logic [2:0] A_C0 = adcts_pkg::OFF_CTRL0;
   localparam logic [2:0] A_C1 = adcts_pkg::OFF_CTRL1;
   localparam logic [2:0] A_FR = adcts_pkg::OFF_FREF;
   localparam logic [2:0] A_MK = adcts_pkg::OFF_MASK;
   localparam logic [2:0] A_ST = adcts_pkg::OFF_STATUS;
   logic                  core_clk, rst, wr_en, rd_en, cmp_in, rc_osc;
   logic                  ref_stable, sleep, irq, wake;
   logic [2:0]            addr;
   logic [7:0]            wr_data, rd_data, v, hi;
   logic [9:0]            last_res;
   adcts_pkg::adcts_ana_t ana;
   int                    n_errors, num_checks;
   logic [2:0]            cs_tab [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2,
                                          3'h6, 3'h3};
   logic [4:0]            ch_tab [7] = '{5'h1f, 5'h01, 5'h02, 5'h03, 5'h1d,
                                          5'h1e, 5'h00};
   adcts_top #(.TEMP_SETTLE(50), .REF_SETTLE(4)) u_dut (.core_clk(core_clk),
      .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .cmp_in(cmp_in), .rc_osc(rc_osc),
      .ref_stable(ref_stable), .ana(ana), .sleep(sleep), .irq(irq),
      .wake(wake));
   adcts_core_model u_core (.ana(ana), .cmp_in(cmp_in), .rc_osc(rc_osc),
      .ref_stable(ref_stable));
   task automatic close_out();
      if (n_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [15:0] e, g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge core_clk);
      wr_en   <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge core_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask : rd
   // reset values, unmapped place, reference control fields
   task automatic t_regs();
      logic [7:0] d;
      wr(3'h7, 8'hff);
      for (int a = 0; a < 8; a++) begin
         rd(a[2:0], v);
         chk("reset value", (a == 2) ? 16'h0040 : 16'h0000, {8'h0, v});
      end
      for (int i = 0; i < 4; i++) begin
         d = {2'b00, i[0], i[1], i[1:0], ~i[1:0]};
         wr(A_FR, d);
         wr(A_C1, {6'h00, i[1:0]});
         rd(A_FR, v);
         chk("fref", {8'h0, d | 8'h40}, {8'h0, v});
         chk("temp_en", {15'h0, i[0]}, {15'h0, ana.temp_en});
         chk("temp_high", {15'h0, i[1]}, {15'h0, ana.temp_high});
         chk("gains", {12'h0, i[1:0], ~i[1:0]},
             {12'h0, ana.periph_gain, ana.conv_gain});
         chk("pos_ref", {14'h0, i[1:0]}, {14'h0, ana.pos_ref});
      end
   endtask : t_regs
   // one conversion: length, flag, mask, busy, result pair, optional sleep
   task automatic t_conv(input logic [2:0] cs, input logic [4:0] ch,
                         input logic fmt, input logic slp);
      int c;
      int h;
      logic [9:0] r;
      h = (cs[1:0] == 2'h3) ? 4 : 1 << (2 * cs[1:0] + cs[2]);
      r = {ch, ch};
      wr(A_C1, {fmt, cs, 4'h0});
      wr(A_C0, {1'b0, ch, 2'b01});
      cyc(60);
      wr(A_C0, {1'b0, ch, 2'b11});
      if (slp) begin
         sleep <= 1'b1;
      end
      c = 0;
      while (irq !== 1'b1 && c < 3000) begin
         cyc(1);
         c++;
      end
      if (c >= 3000) begin
         n_errors++;
         close_out();
      end
      chk("cycles", 16'h1, {15'h0, c >= 23 * h - 4 && c <= 23 * h + 12});
      cyc(1);
      chk("wake", {15'h0, slp}, {15'h0, wake});
      @(posedge core_clk);
      sleep <= 1'b0;
      wr(A_MK, 8'h00);
      cyc(3);
      chk("irq masked", 16'h0, {15'h0, irq});
      wr(A_MK, 8'h01);
      cyc(3);
      chk("irq unmasked", 16'h1, {15'h0, irq});
      rd(A_ST, v);
      chk("done flag", 16'h1, {15'h0, v[0]});
      rd(A_ST, v);
      chk("flag cleared", 16'h0, {15'h0, v[0]});
      rd(A_C0, v);
      chk("on and busy", 16'h1, {14'h0, v[1:0]});
      rd(adcts_pkg::OFF_RES_HI, hi);
      rd(adcts_pkg::OFF_RES_LO, v);
      chk("result", fmt ? {6'h0, r} : {r, 6'h0}, {hi, v});
      last_res = r;
   endtask : t_conv
   // sleep on a divided clock cuts the conversion short, results hold
   task automatic t_abort();
      wr(A_C1, {1'b1, adcts_pkg::CS_DIV64, 4'h0});
      wr(A_C0, 8'h7f);
      cyc(100);
      @(posedge core_clk);
      sleep <= 1'b1;
      cyc(900);
      chk("aborted irq", 16'h0, {15'h0, irq});
      @(posedge core_clk);
      sleep <= 1'b0;
      rd(adcts_pkg::OFF_RES_HI, hi);
      rd(adcts_pkg::OFF_RES_LO, v);
      chk("held result", {6'h0, last_res}, {hi, v});
   endtask : t_abort
   // clearing go after two decided bits keeps them and fills the rest
   task automatic t_term();
      wr(A_C0, 8'h2b);
      cyc(250);
      wr(A_C0, 8'h29);
      cyc(2);
      rd(A_C0, v);
      chk("terminated", 16'h1, {14'h0, v[1:0]});
      rd(adcts_pkg::OFF_RES_HI, hi);
      rd(adcts_pkg::OFF_RES_LO, v);
      chk("partial result", 16'h01ff, {hi, v});
   endtask : t_term
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      rst        = 1'b1;
      addr       = 3'h0;
      wr_data    = 8'h00;
      wr_en      = 1'b0;
      rd_en      = 1'b0;
      sleep      = 1'b0;
      n_errors   = 0;
      num_checks = 0;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      t_regs();
      wr(A_MK, 8'h01);
      for (int i = 0; i < 7; i++) begin
         t_conv(cs_tab[i], ch_tab[i], ~i[0], 1'b0);
      end
      t_abort();
      t_term();
      t_conv(3'h7, 5'h02, 1'b1, 1'b1);
      close_out();
   end
endmodule : tb
